/* hw/ict_regs.svh */
`ifndef ICT_REGS_SVH
`define ICT_REGS_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
// system clock period in ns
`define ICT_CLK_PERIOD_NS 10
// system clocks per instruction cycle
`define ICT_CLKS_PER_CYCLE 4
// ----------------------------------------------------------------------
// address map and field positions
// ----------------------------------------------------------------------
// data memory byte that aliases the program counter low byte
`define ICT_PC_LOW_ADDR 8'h02
// program memory page that holds constant tables
`define ICT_TBL_PAGE 3'h7
// program counter after reset
`define ICT_PC_RESET 11'h000
// instruction fields
`define ICT_OP_MSB 15
`define ICT_OP_LSB 11
`define ICT_DEST_BIT 10
// sub-codes of the system group, held in the bit index field
`define ICT_SUB_NOP 3'h0
`define ICT_SUB_EXIT 3'h1
`define ICT_SUB_HALT 3'h2
`define ICT_SUB_TABRD 3'h3
`endif

/* hw/ict_pkg.sv */
package ict_pkg;
   // one-hot phases of one instruction cycle
   typedef enum logic [3:0] {
      ph_read = 4'h1,
      ph_load = 4'h2,
      ph_calc = 4'h4,
      ph_commit = 4'h8
   } ict_phase_t;
   // major opcodes, bits 15..11 of the instruction word
   typedef enum logic [4:0] {
      op_sys = 5'h00, op_add = 5'h01, op_adc = 5'h02, op_sub = 5'h03,
      op_sbc = 5'h04, op_and = 5'h05, op_or = 5'h06, op_xor = 5'h07,
      op_comp = 5'h08, op_inc = 5'h09, op_decr = 5'h0a, op_rot_r = 5'h0b,
      op_rot_rc = 5'h0c, op_rot_l = 5'h0d, op_rot_lc = 5'h0e,
      op_mova = 5'h0f,
      op_movm = 5'h10, op_addi = 5'h11, op_subi = 5'h12, op_andi = 5'h13,
      op_ori = 5'h14, op_xori = 5'h15, op_movi = 5'h16, op_clrb = 5'h17,
      op_setb = 5'h18, op_sz = 5'h19, op_szb = 5'h1a, op_snzb = 5'h1b,
      op_siz = 5'h1c, op_sdz = 5'h1d, op_branch = 5'h1e, op_call = 5'h1f
   } ict_op_t;
endpackage : ict_pkg

/* hw/ict_dmem_if.sv */
`timescale 1ns/1ps
`default_nettype none
// data memory port between the core and its ram
interface ict_dmem_if;
   logic [7:0] addr;
   logic we;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport core (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface : ict_dmem_if
`default_nettype wire

/* hw/ict_ram.sv */
`timescale 1ns/1ps
`default_nettype none
// 256 x 8 data memory, read data registered
module ict_ram (
   input wire logic i_clk,
   ict_dmem_if.mem bus
);
   logic [7:0] cells [0:255]; // storage, no reset
   // ---------------------------------------------------------------
   // write, and registered read of the old contents of the same address
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (bus.we) begin
         cells[bus.addr] <= bus.wdata;
      end
      bus.rdata <= cells[bus.addr];
   end
endmodule : ict_ram
`default_nettype wire

/* hw/ict_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ict_regs.svh"
module ict_core (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [15:0] i_prog_data,
   input wire logic i_wake,
   output logic [10:0] o_prog_addr,
   output logic [7:0] o_acc,
   output logic [3:0] o_flags,
   output logic o_halted,
   output logic o_retire
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ict_pkg::ict_phase_t phase; // position inside the cycle
   logic [15:0] ir; // instruction being executed
   logic ir_valid; // low for a discarded slot
   logic [10:0] pc; // address fetched in this cycle
   logic [7:0] acc; // accumulator
   logic z, c, ac, ov; // status flags
   logic [7:0] opnd; // data memory operand
   logic halted; // power-down state
   logic [10:0] stack [0:7]; // return addresses
   logic [2:0] sp; // next free stack slot
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   ict_pkg::ict_op_t op;
   logic d; // result goes to memory
   logic [2:0] idx; // bit index or sub-code
   logic [7:0] m; // address or immediate
   logic [7:0] mask; // one-hot bit select
   logic exec; // commit edge of a valid slot
   assign op = ict_pkg::ict_op_t'(ir[`ICT_OP_MSB:`ICT_OP_LSB]);
   assign d = ir[`ICT_DEST_BIT];
   assign idx = ir[10:8];
   assign m = ir[7:0];
   assign mask = 8'h01 << idx;
   assign exec = (phase == ict_pkg::ph_commit) && ir_valid;
   // ----------------------------------------------------------------
   // adder operands
   // ----------------------------------------------------------------
   logic [7:0] arith_b; // second operand, inverted for subtract
   logic arith_cin; // carry in, one means no borrow
   logic [8:0] sum; // nine bits keep the carry out
   logic [4:0] nib; // low nibble for the aux carry
   // subtract is acc plus inverted operand plus one
   always_comb begin
      arith_b = opnd;
      arith_cin = 1'b0;
      case (op)
         ict_pkg::op_adc: begin
            arith_cin = c;
         end
         ict_pkg::op_sub: begin
            arith_b = ~opnd;
            arith_cin = 1'b1;
         end
         ict_pkg::op_sbc: begin
            arith_b = ~opnd;
            arith_cin = c;
         end
         ict_pkg::op_addi: begin
            arith_b = m;
         end
         ict_pkg::op_subi: begin
            arith_b = ~m;
            arith_cin = 1'b1;
         end
         default: begin
         end
      endcase
   end
   // acc is always the first operand
   assign sum = {1'b0, acc} + {1'b0, arith_b} + {8'h00, arith_cin};
   assign nib = {1'b0, acc[3:0]} + {1'b0, arith_b[3:0]} + {4'h0, arith_cin};
   // ----------------------------------------------------------------
   // execute
   // ----------------------------------------------------------------
   logic [7:0] res; // result byte
   logic dst_mem, dst_acc; // result targets
   logic upd_z, upd_arith, upd_c; // flag updates
   logic n_c; // new carry from a rotate
   logic skip, jump, push, pop, halt_go, tbl;
   logic [10:0] jtarget; // new program counter
   // result, target and control per opcode
   always_comb begin
      res = acc;
      dst_mem = 1'b0;
      dst_acc = 1'b0;
      upd_z = 1'b0;
      upd_arith = 1'b0;
      upd_c = 1'b0;
      n_c = c;
      skip = 1'b0;
      jump = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      halt_go = 1'b0;
      tbl = 1'b0;
      jtarget = pc;
      case (op)
         ict_pkg::op_sys: begin
            case (idx)
               `ICT_SUB_EXIT: begin
                  // resume after the call
                  pop = 1'b1;
                  jump = 1'b1;
                  jtarget = stack[sp - 3'h1];
               end
               `ICT_SUB_HALT: begin
                  halt_go = 1'b1;
               end
               `ICT_SUB_TABRD: begin
                  // table word low byte into memory
                  tbl = 1'b1;
                  res = i_prog_data[7:0];
                  dst_mem = 1'b1;
               end
               default: begin
               end
            endcase
         end
         ict_pkg::op_add, ict_pkg::op_adc, ict_pkg::op_sub,
         ict_pkg::op_sbc: begin
            res = sum[7:0];
            upd_arith = 1'b1;
            dst_mem = d;
            dst_acc = ~d;
         end
         ict_pkg::op_addi, ict_pkg::op_subi: begin
            res = sum[7:0];
            upd_arith = 1'b1;
            dst_acc = 1'b1;
         end
         ict_pkg::op_and, ict_pkg::op_or, ict_pkg::op_xor,
         ict_pkg::op_comp: begin
            case (op)
               ict_pkg::op_and: res = acc & opnd;
               ict_pkg::op_or: res = acc | opnd;
               ict_pkg::op_xor: res = acc ^ opnd;
               default: res = ~opnd;
            endcase
            upd_z = 1'b1;
            dst_mem = d;
            dst_acc = ~d;
         end
         ict_pkg::op_andi, ict_pkg::op_ori, ict_pkg::op_xori: begin
            case (op)
               ict_pkg::op_andi: res = acc & m;
               ict_pkg::op_ori: res = acc | m;
               default: res = acc ^ m;
            endcase
            upd_z = 1'b1;
            dst_acc = 1'b1;
         end
         ict_pkg::op_inc, ict_pkg::op_decr: begin
            // step of exactly one
            res = (op == ict_pkg::op_inc) ? opnd + 8'h01 : opnd - 8'h01;
            upd_z = 1'b1;
            dst_mem = d;
            dst_acc = ~d;
         end
         ict_pkg::op_rot_r, ict_pkg::op_rot_rc, ict_pkg::op_rot_l,
         ict_pkg::op_rot_lc: begin
            // one position; carry variants swap bit with carry
            case (op)
               ict_pkg::op_rot_r: res = {opnd[0], opnd[7:1]};
               ict_pkg::op_rot_rc: res = {c, opnd[7:1]};
               ict_pkg::op_rot_l: res = {opnd[6:0], opnd[7]};
               default: res = {opnd[6:0], c};
            endcase
            upd_c = (op == ict_pkg::op_rot_rc) || (op == ict_pkg::op_rot_lc);
            n_c = (op == ict_pkg::op_rot_rc) ? opnd[0] : opnd[7];
            dst_mem = d;
            dst_acc = ~d;
         end
         ict_pkg::op_mova: begin
            res = opnd;
            dst_acc = 1'b1;
         end
         ict_pkg::op_movm: begin
            res = acc;
            dst_mem = 1'b1;
         end
         ict_pkg::op_movi: begin
            res = m;
            dst_acc = 1'b1;
         end
         ict_pkg::op_clrb, ict_pkg::op_setb: begin
            // read-modify-write of one bit
            res = (op == ict_pkg::op_setb) ? (opnd | mask) : (opnd & ~mask);
            dst_mem = 1'b1;
         end
         ict_pkg::op_sz: begin
            // test byte, optional copy to acc
            res = opnd;
            dst_acc = d;
            skip = (opnd == 8'h00);
         end
         ict_pkg::op_szb, ict_pkg::op_snzb: begin
            res = opnd;
            skip = ((opnd & mask) == 8'h00) == (op == ict_pkg::op_szb);
         end
         ict_pkg::op_siz, ict_pkg::op_sdz: begin
            // step then skip on zero
            res = (op == ict_pkg::op_siz) ? opnd + 8'h01 : opnd - 8'h01;
            skip = (op == ict_pkg::op_siz) ? (opnd == 8'hff) : (opnd == 8'h01);
            dst_mem = d;
            dst_acc = ~d;
         end
         ict_pkg::op_branch, ict_pkg::op_call: begin
            // jump saves nothing, call saves
            jump = 1'b1;
            push = (op == ict_pkg::op_call);
            jtarget = ir[10:0];
         end
         default: begin
         end
      endcase
   end
   // ----------------------------------------------------------------
   // data memory port
   // ----------------------------------------------------------------
   ict_dmem_if dmem ();
   logic pc_low_wr; // memory write to the pc low alias
   assign dmem.addr = m;
   assign dmem.we = exec && dst_mem;
   assign dmem.wdata = res;
   assign pc_low_wr = exec && dst_mem && (m == `ICT_PC_LOW_ADDR);
   ict_ram u_ram (
      .i_clk (i_clk),
      .bus (dmem)
   );
   // ----------------------------------------------------------------
   // phase sequencer
   // ----------------------------------------------------------------
   // four clocks per cycle, parked in read phase while halted
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         phase <= ict_pkg::ph_read;
      end else begin
         case (phase)
            ict_pkg::ph_read: begin
               if (!halted || i_wake) begin
                  phase <= ict_pkg::ph_load;
               end
            end
            ict_pkg::ph_load: phase <= ict_pkg::ph_calc;
            ict_pkg::ph_calc: phase <= ict_pkg::ph_commit;
            ict_pkg::ph_commit: phase <= ict_pkg::ph_read;
            default: phase <= ict_pkg::ph_read;
         endcase
      end
   end
   // operand capture two clocks after the read address settles
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         opnd <= 8'h00;
      end else if (phase == ict_pkg::ph_load) begin
         opnd <= dmem.rdata;
      end
   end
   // ----------------------------------------------------------------
   // fetch and program flow
   // ----------------------------------------------------------------
   // table read borrows this cycle's fetch slot
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_prog_addr <= `ICT_PC_RESET;
      end else if (phase == ict_pkg::ph_read) begin
         o_prog_addr <= (ir_valid && tbl) ? {`ICT_TBL_PAGE, acc} : pc;
      end
   end
   // redirects drop the fetched word, costing one cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pc <= `ICT_PC_RESET;
         ir <= 16'h0000;
         ir_valid <= 1'b0;
      end else if (phase == ict_pkg::ph_commit) begin
         ir <= i_prog_data;
         ir_valid <= 1'b0;
         if (!ir_valid) begin
            // discarded slot just refills
            pc <= pc + 11'h001;
            ir_valid <= 1'b1;
         end else if (jump) begin
            pc <= jtarget;
         end else if (pc_low_wr) begin
            pc <= {pc[10:8], res};
         end else if (skip) begin
            pc <= pc + 11'h001;
         end else if (!tbl) begin
            pc <= pc + 11'h001;
            ir_valid <= 1'b1;
         end
      end
   end
   // return stack, circular
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sp <= 3'h0;
      end else if (exec && push) begin
         stack[sp] <= pc;
         sp <= sp + 3'h1;
      end else if (exec && pop) begin
         sp <= sp - 3'h1;
      end
   end
   // ----------------------------------------------------------------
   // accumulator and flags
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         acc <= 8'h00;
         {z, c, ac, ov} <= 4'h0;
      end else if (exec) begin
         if (dst_acc) begin
            acc <= res;
         end
         if (upd_z || upd_arith) begin
            z <= (res == 8'h00);
         end
         if (upd_arith) begin
            // carry one means no borrow for subtract
            c <= sum[8];
            ac <= nib[4];
            ov <= (acc[7] == arith_b[7]) && (sum[7] != acc[7]);
         end
         if (upd_c) begin
            c <= n_c;
         end
      end
   end
   // power-down until wake; a halt commit wins over a wake
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         halted <= 1'b0;
      end else if (exec && halt_go) begin
         halted <= 1'b1;
      end else if (i_wake) begin
         halted <= 1'b0;
      end
   end
   // retire pulse for each executed slot
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_retire <= 1'b0;
      end else begin
         o_retire <= exec;
      end
   end
   assign o_acc = acc;
   assign o_flags = {ov, ac, c, z};
   assign o_halted = halted;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // one clock domain, so every check below shares this clock and reset
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   a_cycle_four_clk: assert property (
      (phase == ict_pkg::ph_read && !halted) |=> phase == ict_pkg::ph_load
      ##1 phase == ict_pkg::ph_calc ##1 phase == ict_pkg::ph_commit
      ##1 phase == ict_pkg::ph_read)
      else $error("instruction cycle is not four clocks");
   a_jump_flush: assert property (
      (exec && jump) |=> !ir_valid && pc == $past(jtarget))
      else $error("jump did not drop the fetched word");
   a_jump_no_save: assert property (
      (exec && jump && !push && !pop) |=> sp == $past(sp))
      else $error("jump changed the return stack");
   a_call_save: assert property (
      (exec && push) |=> stack[sp - 3'h1] == $past(pc))
      else $error("call did not save the return point");
   a_skip_taken: assert property (
      (exec && skip && !jump) |=> !ir_valid ##3 !o_retire ##1 !o_retire)
      else $error("taken skip executed the next word");
   a_skip_none: assert property (
      (exec && (op == ict_pkg::op_sz) && !skip && !pc_low_wr) |=> ir_valid)
      else $error("untaken skip lost a cycle");
   a_logic_zero: assert property (
      (exec && upd_z) |=> z == ($past(res) == 8'h00))
      else $error("zero flag wrong after logic op");
   a_bit_only: assert property (
      (exec && (op == ict_pkg::op_clrb || op == ict_pkg::op_setb))
      |-> ((dmem.wdata ^ opnd) & ~mask) == 8'h00)
      else $error("bit op changed another bit");
   a_pc_low_jump: assert property (
      pc_low_wr && !jump |=> !ir_valid && pc[7:0] == $past(res))
      else $error("pc low write did not jump");
   a_add_carry: assert property (
      (exec && op == ict_pkg::op_add)
      |=> c == ({1'b0, $past(acc)} + {1'b0, $past(opnd)} > 9'h0ff))
      else $error("carry wrong after add");
   a_table_addr: assert property (
      (exec && tbl) |-> o_prog_addr == {`ICT_TBL_PAGE, acc})
      else $error("table read fetched wrong address");
   a_halt_hold: assert property (
      (halted && !i_wake && phase == ict_pkg::ph_read)
      |=> halted && phase == ict_pkg::ph_read)
      else $error("core ran while halted");
endmodule : ict_core
`default_nettype wire

/* sim/ict_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// program memory model: word valid lat - 1 clocks (at least one) after the address moves
// ----------------------------------------------------------------------
module ict_prog_mem #(
   parameter int LAT = 3 // 1 answers promptly, 3 at the last moment
) (
   input wire logic i_clk,
   input wire logic [10:0] i_addr,
   output logic [15:0] o_data
);
   logic [15:0] rom [2048]; // program words, placed by the bench
   logic [10:0] last_addr = 11'h000; // address held at the last edge
   int age = 0; // clocks the address has stood
   // restart the age count whenever the core moves the address
   always @(posedge i_clk) begin
      last_addr <= i_addr;
      if (i_addr !== last_addr) age <= 1;
      else if (age < 8) age <= age + 1;
   end
   // before the word is ready the bus shows a changing wrong pattern
   always_comb begin
      if (i_addr === last_addr && age >= LAT - 1) o_data = rom[i_addr];
      else o_data = ~rom[i_addr] ^ 16'(age);
   end
endmodule : ict_prog_mem
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ---------------------------------------------------------------
   // core, slow program memory and clock
   // ---------------------------------------------------------------
   logic i_clk = 1'b0; // system clock
   logic i_reset; // synchronous reset
   logic i_wake; // leaves halt
   logic [15:0] prog_data; // fetched word
   logic [10:0] prog_addr; // fetch address
   logic [7:0] acc_out; // accumulator port
   logic [3:0] flags_out; // {ov, ac, c, z}
   logic halted; // power-down level
   logic retire; // pulse per executed instruction
   int err_count = 0; // mismatches
   int n_checks = 0; // comparisons
   int seed = 32'hc1e4; // fixed seed
   logic [7:0] acc; // expected accumulator
   logic [3:0] fl; // expected flags
   logic [7:0] dm [256]; // expected data memory
   logic [10:0] pc; // next program slot
   logic [10:0] stk [$]; // open call return points
   int prev = 0; // cycles of the previous instruction
   logic [7:0] q_acc [$]; // expected values per retire
   logic [3:0] q_fl [$];
   int q_gap [$];
   logic q_halt [$];
   ict_core u_dut (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_prog_data(prog_data),
      .i_wake(i_wake),
      .o_prog_addr(prog_addr),
      .o_acc(acc_out),
      .o_flags(flags_out),
      .o_halted(halted),
      .o_retire(retire)
   );
   ict_prog_mem #(.LAT(3)) u_mem (
      .i_clk(i_clk),
      .i_addr(prog_addr),
      .o_data(prog_data)
   );
   always #5 i_clk = ~i_clk; // 100 MHz
   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   // add or subtract, returns {ov, ac, c, z, result}
   function automatic logic [11:0] arith(logic [7:0] x, logic [7:0] y,
                                         logic ci, logic sb);
      logic [7:0] yy;
      logic [8:0] sum;
      logic [4:0] half;
      yy = sb ? ~y : y;
      sum = {1'b0, x} + {1'b0, yy} + {8'h00, ci};
      half = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + {4'h0, ci};
      return {(x[7] == yy[7]) && (sum[7] != x[7]), half[4], sum[8],
              sum[7:0] == 8'h00, sum[7:0]};
   endfunction : arith
   // place one word and note what its retire must show
   task automatic ex(logic [4:0] op, logic [2:0] mid, logic [7:0] lo);
      logic [7:0] m, b, r;
      logic [11:0] a;
      logic [31:0] w;
      logic [10:0] tgt;
      logic d, wr, tk, h, j, s, ci;
      int cyc;
      m = dm[lo];
      d = mid[2] && op inside {[5'h01:5'h0e], 5'h19, 5'h1c, 5'h1d};
      {wr, tk, h, j, cyc, r} = {4'b1000, 32'd1, m};
      u_mem.rom[pc] = {op, mid, lo};
      pc = pc + 11'h001;
      b = (op > 5'h10) ? lo : m;
      s = op inside {ict_pkg::op_sub, ict_pkg::op_sbc, ict_pkg::op_subi};
      ci = op inside {ict_pkg::op_adc, ict_pkg::op_sbc} ? fl[1] : s;
      case (op)
         ict_pkg::op_add, ict_pkg::op_adc, ict_pkg::op_sub, ict_pkg::op_sbc,
         ict_pkg::op_addi, ict_pkg::op_subi: begin
            a = arith(acc, b, ci, s);
            {fl, r} = a;
         end
         ict_pkg::op_and, ict_pkg::op_andi: r = acc & b;
         ict_pkg::op_or, ict_pkg::op_ori: r = acc | b;
         ict_pkg::op_xor, ict_pkg::op_xori: r = acc ^ b;
         ict_pkg::op_comp: r = ~m;
         ict_pkg::op_inc: r = m + 8'h01;
         ict_pkg::op_decr: r = m - 8'h01;
         ict_pkg::op_rot_r: r = {m[0], m[7:1]};
         ict_pkg::op_rot_l: r = {m[6:0], m[7]};
         ict_pkg::op_rot_rc: {r, fl[1]} = {fl[1], m};
         ict_pkg::op_rot_lc: {fl[1], r} = {m, fl[1]};
         ict_pkg::op_movm: {d, r} = {1'b1, acc};
         ict_pkg::op_movi: r = b;
         ict_pkg::op_clrb, ict_pkg::op_setb: begin
            r[mid] = (op == ict_pkg::op_setb);
            d = 1'b1;
         end
         ict_pkg::op_sz: {tk, wr, d} = {m == 8'h00, d, 1'b0};
         ict_pkg::op_szb: {tk, wr} = {!m[mid], 1'b0};
         ict_pkg::op_snzb: {tk, wr} = {m[mid], 1'b0};
         ict_pkg::op_siz: r = m + 8'h01;
         ict_pkg::op_sdz: r = m - 8'h01;
         ict_pkg::op_branch: {j, wr, tgt} = {2'b10, mid, lo};
         ict_pkg::op_call: begin
            stk.push_back(pc);
            {j, wr, tgt} = {2'b10, mid, lo};
         end
         ict_pkg::op_sys: begin
            {wr, d, h} = {mid == 3'h3, 1'b1, mid == 3'h2};
            if (mid == 3'h1) {j, tgt} = {1'b1, stk.pop_back()};
            if (wr) begin
               w = $random(seed);
               u_mem.rom[{3'h7, acc}] = w[15:0];
               {r, cyc} = {w[7:0], 32'd2};
            end
         end
         default: wr = 1'b1;
      endcase
      if (op inside {[5'h05:5'h0a], [5'h13:5'h15]}) fl[0] = r == 8'h00;
      if (op inside {5'h1c, 5'h1d}) tk = r == 8'h00;
      if (wr && d) dm[lo] = r;
      if (wr && !d) acc = r;
      if (wr && d && lo == 8'h02) {j, tgt} = {1'b1, pc[10:8], r};
      if (tk || j) begin
         u_mem.rom[pc] = 16'hb0ee; // must be dropped
         pc = j ? tgt : pc + 11'h001;
         cyc = 2;
      end
      q_acc.push_back(acc);
      q_fl.push_back(fl);
      q_gap.push_back(prev * 4);
      q_halt.push_back(h);
      prev = h ? 0 : cyc;
   endtask : ex
   // compare and count
   task automatic chk(string nm, logic [7:0] e, logic [7:0] v);
      n_checks++;
      if (e !== v) begin
         $display("wrong value %s expected %h seen %h", nm, e, v);
         err_count++;
      end
   endtask : chk
   task automatic give_verdict;
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   // ---------------------------------------------------------------
   // program, then run and compare at every retire
   // ---------------------------------------------------------------
   initial begin
      int i, gap, e;
      logic [31:0] v;
      logic [4:0] o;
      logic h;
      {i_reset, i_wake, pc, acc, fl} = {2'b10, 11'h000, 8'h00, 4'h0};
      for (i = 0; i < 8; i++) begin
         v = $random(seed);
         ex(ict_pkg::op_movi, 3'h0, v[7:0]);
         ex(ict_pkg::op_movm, 3'h0, 8'h20 + 8'(i));
      end
      ex(ict_pkg::op_movi, 3'h0, 8'hff);
      ex(ict_pkg::op_addi, 3'h0, 8'h01);
      ex(ict_pkg::op_movi, 3'h0, 8'h7f);
      ex(ict_pkg::op_addi, 3'h0, 8'h01);
      ex(ict_pkg::op_subi, 3'h0, 8'h81);
      ex(ict_pkg::op_sbc, 3'h4, 8'h20);
      ex(ict_pkg::op_mova, 3'h0, 8'h20);
      ex(ict_pkg::op_movi, 3'h0, pc[7:0] + 8'h03);
      ex(ict_pkg::op_movm, 3'h0, 8'h02);
      v[10:0] = pc + 11'h002;
      ex(ict_pkg::op_branch, v[10:8], v[7:0]);
      ex(ict_pkg::op_call, 3'h4, 8'h00);
      ex(ict_pkg::op_movi, 3'h0, 8'h5a);
      ex(ict_pkg::op_sys, 3'h1, 8'h00);
      ex(ict_pkg::op_movi, 3'h0, 8'hff);
      ex(ict_pkg::op_movm, 3'h0, 8'h29);
      ex(ict_pkg::op_movi, 3'h0, 8'h00);
      ex(ict_pkg::op_siz, 3'h4, 8'h29);
      ex(ict_pkg::op_movi, 3'h0, 8'hff);
      ex(ict_pkg::op_sdz, 3'h0, 8'h29);
      ex(ict_pkg::op_mova, 3'h0, 8'h29);
      for (i = 0; i < 80; i++) begin
         v = $random(seed);
         o = 5'h01 + 5'(v[15:8] % 8'd27);
         if (o inside {[5'h11:5'h16]}) ex(o, 3'h0, v[7:0]);
         else ex(o, v[18:16], {5'h04, v[2:0]});
      end
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         // low bits from the loop keep the three table words apart
         ex(ict_pkg::op_movi, 3'h0, {v[7:2], 2'(i)});
         ex(ict_pkg::op_sys, 3'h3, 8'h2a);
         ex(ict_pkg::op_mova, 3'h0, 8'h2a);
      end
      ex(ict_pkg::op_sys, 3'h0, 8'h00);
      ex(ict_pkg::op_sys, 3'h2, 8'h00);
      ex(ict_pkg::op_movi, 3'h0, 8'h3c);
      repeat (4) @(negedge i_clk);
      i_reset = 1'b0;
      while (q_acc.size() > 0) begin
         gap = 0;
         do begin
            @(negedge i_clk);
            gap++;
         end while (retire !== 1'b1 && gap < 40);
         if (retire !== 1'b1) begin
            err_count++;
            give_verdict();
         end
         e = q_gap.pop_front();
         h = q_halt.pop_front();
         if (e > 0) chk("cycles", 8'(e), 8'(gap));
         chk("acc", q_acc.pop_front(), acc_out);
         chk("flags", {4'h0, q_fl.pop_front()}, {4'h0, flags_out});
         if (!h) chk("halted", 8'h00, {7'h00, halted});
         if (h) begin
            repeat (20) begin
               @(negedge i_clk);
               chk("halt", 8'h02, {6'h00, halted, retire});
            end
            i_wake = 1'b1;
            @(negedge i_clk);
            i_wake = 1'b0;
         end
      end
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
